//--- src/tenbase_t_pkg.sv
// Package for the 10 Mb/s twisted-pair transceiver control block.
// Assumes a 200 MHz system clock; all timing constants are derived from it.
package tenbase_t_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;

  // Printed times in their own units
  localparam int unsigned SQ_WINDOW_NS = 150;
  localparam int unsigned SQ_IDLE_NS = 150;
  localparam int unsigned BIT_NS = 100;
  localparam int unsigned COL_BITS = 7;
  localparam int unsigned SQE_DELAY_NS = 1000;
  localparam int unsigned SQE_BITS = 10;
  localparam int unsigned NLP_WIDTH_NS = 100;
  localparam int unsigned NLP_PERIOD_MS = 16;
  localparam int unsigned JAB_MS = 26;
  localparam int unsigned UNJAB_MS = 750;
  localparam int unsigned LINK_LOSS_MS = 100;
  localparam int unsigned POL_LINK_COUNT = 7;
  localparam int unsigned POL_EOP_COUNT = 3;

  // Derived cycle counts (longest times round down, least times round up)
  localparam int unsigned SQ_WINDOW_CYC = SQ_WINDOW_NS / CLK_NS;
  localparam int unsigned SQ_IDLE_CYC = (SQ_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned COL_CYC = (COL_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SQE_DELAY_CYC = SQE_DELAY_NS / CLK_NS;
  localparam int unsigned SQE_WIDTH_CYC = SQE_BITS * BIT_NS / CLK_NS;
  localparam int unsigned NLP_WIDTH_CYC = NLP_WIDTH_NS / CLK_NS;
  localparam int unsigned NLP_PERIOD_CYC = NLP_PERIOD_MS * CLK_PER_MS;
  localparam int unsigned JAB_CYC = JAB_MS * CLK_PER_MS;
  localparam int unsigned UNJAB_CYC = UNJAB_MS * CLK_PER_MS;
  localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * CLK_PER_MS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PCS_CFG_IDX = 8'h17;
  localparam logic [7:0] LOOPBACK_MASK_IDX = 8'h18;
  localparam logic [7:0] TEN_CFG_IDX = 8'h1c;
  localparam logic [7:0] TEN_CTRL_IDX = 8'h20;
  localparam logic [7:0] TEN_STAT_IDX = 8'h21;

  // Field positions
  localparam int unsigned REPEATER_BIT = 12;
  localparam int unsigned FD_CRS_TX_BIT = 6;
  localparam int unsigned LOOPBACK_BIT = 11;
  localparam int unsigned LOW_SQUELCH_BIT = 2;
  localparam int unsigned CABLE_TYPE_BIT = 3;
  localparam int unsigned HEARTBEAT_BIT = 0;
  localparam int unsigned LINK_INT_BIT = 1;

  // Reset values
  localparam logic HEARTBEAT_RST = 1'b1;
  localparam logic LINK_INT_RST = 1'b1;

  // Squelch states (one-hot)
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_FIRST = 4'h2,
    SQ_SECOND = 4'h4,
    SQ_VALID = 4'h8
  } sq_state_t;

  // Jabber states (one-hot)
  typedef enum logic [1:0] {
    JAB_OK = 2'h1,
    JAB_LOCK = 2'h2
  } jab_state_t;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Active-low status outputs
  typedef struct packed {
    logic txN;
    logic rxN;
    logic linkN;
    logic polarityN;
    logic colN;
  } led_t;

endpackage : tenbase_t_pkg

//--- src/tenbase_t_transceiver_control.sv
// Control logic for a 10 Mb/s twisted-pair transceiver: squelch qualification,
// collision and heartbeat, carrier sense, link pulses, jabber, polarity,
// output pair select, loopback and status outputs, with an APB register slave.
// Assumes threshold crossings and link pulse detection come in as one-cycle
// pulses synchronous to clk, and the Manchester encoder drives txData.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Full duplex never raises collision from simultaneous transmit and receive.
// - Start needs first crossing, opposite within 150ns, original again within 150ns.
// - After qualification thresholds drop; 150ns without crossing ends the packet.
// - Low squelch bit 2 of register 1Ch selects the reduced receive threshold.
// - Half duplex collision means receive and transmit active together, shown on COL.
// - While transmitting, collision is reported after seven bit times in collision.
// - COL holds for the whole collision and drops when it ends.
// - Heartbeat gives a 10-bit-time pulse on COL 1us after transmit ends.
// - Half duplex carrier sense follows transmit or qualified receive.
// - Full duplex carrier sense follows receive, or transmit when bit 6 of 18h set.
// - Repeater mode, by strap or bit 12 of 17h, senses receive only.
// - Idle line sends 100ns link pulses every 16ms.
// - Missing link pulses with integrity on disable transmit, receive and collision.
// - Integrity off ignores link pulses and keeps the link indicator lit.
// - Loopback bit 11 of 18h loops transmit to receive, drivers off, link ignored.
// - Transmit active over 26ms jabbers; stays off while transmit enable holds.
// - Jabber clears only after transmit enable is low for 750ms continuously.
// - Bit 3 of 1Ch picks the unshielded or shielded pair; the other floats.
// - At 100 Mb/s both transmit pairs float.
// - Seven inverted link pulses or three inverted packet ends latch and correct polarity.
// - Five active-low outputs: transmit, receive, link, polarity, collision.
module tenbase_t_transceiver_control #(
  parameter int unsigned NLP_PERIOD = tenbase_t_pkg::NLP_PERIOD_CYC,
  parameter int unsigned JAB_LIMIT = tenbase_t_pkg::JAB_CYC,
  parameter int unsigned UNJAB_LIMIT = tenbase_t_pkg::UNJAB_CYC,
  parameter int unsigned LINK_LOSS = tenbase_t_pkg::LINK_LOSS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire tenbase_t_pkg::apb_req_t apbReq,
  output tenbase_t_pkg::apb_rsp_t apbRsp,
  input wire logic fullDuplex,
  input wire logic repeaterStrap,
  input wire logic speed100,
  input wire logic link100Good,
  input wire logic txEn,
  input wire logic txData,
  input wire logic rxDataIn,
  input wire logic rxPosCross,
  input wire logic rxNegCross,
  input wire logic linkPulseGood,
  input wire logic linkPulseInverted,
  input wire logic eopGood,
  input wire logic eopInverted,
  output logic lowSquelchSelect,
  output logic reducedThreshold,
  output logic col,
  output logic crs,
  output logic rxDataOut,
  output logic polarityCorrect,
  output logic unshieldedTxOut,
  output logic unshieldedTxOe,
  output logic shieldedTxOut,
  output logic shieldedTxOe,
  output tenbase_t_pkg::led_t leds
);

  typedef struct packed {
    tenbase_t_pkg::sq_state_t sq;
    logic sqFirstPos;
    logic [7:0] sqCnt;
    logic [7:0] colCnt;
    logic colRep;
    logic txEnPrev;
    logic sqeArm;
    logic sqeOn;
    logic [8:0] sqeCnt;
    logic [27:0] nlpCnt;
    logic nlpOn;
    logic [4:0] nlpW;
    tenbase_t_pkg::jab_state_t jab;
    logic [27:0] jabCnt;
    logic linkGood;
    logic [27:0] linkCnt;
    logic [2:0] polLinkCnt;
    logic [1:0] polEopCnt;
    logic polBad;
    logic lowSq;
    logic cableStp;
    logic fdCrsTx;
    logic loopback;
    logic repeaterBit;
    logic hbEn;
    logic linkIntEn;
    logic [31:0] prdata;
    logic pslverr;
    logic crs;
    logic col;
    logic rxOut;
    logic utpOut;
    logic utpOe;
    logic stpOut;
    logic stpOe;
    tenbase_t_pkg::led_t leds;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Saturating 28-bit counter step, used by all long timers
  function automatic logic [27:0] bump(input logic [27:0] c);
    bump = (c == 28'hfffffff) ? c : c + 28'h0000001;
  endfunction : bump

  // Register index from a byte address, or all ones when misaligned
  function automatic logic [7:0] regIndex(input logic [7:0] a);
    regIndex = (a[1:0] == 2'h0) ? {2'h0, a[7:2]} : 8'hff;
  endfunction : regIndex

  logic repeater;
  logic linkOk;
  logic rxActive;
  logic txActive;
  logic collision;
  logic apbWrite;
  logic [7:0] idx;

  // Qualifiers shared by the next-state logic
  assign repeater = repeaterStrap | st_ff.repeaterBit;
  assign linkOk = !st_ff.linkIntEn || st_ff.linkGood || st_ff.loopback;
  assign rxActive = st_ff.loopback ? txEn : (st_ff.sq == tenbase_t_pkg::SQ_VALID);
  assign txActive = txEn && (st_ff.jab == tenbase_t_pkg::JAB_OK) && linkOk && !speed100;
  assign collision = !fullDuplex && !st_ff.loopback && linkOk && txActive && rxActive;
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign idx = regIndex(apbReq.paddr);

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;

    // Register writes take effect in the access phase
    if (apbWrite) begin
      case (idx)
        tenbase_t_pkg::PCS_CFG_IDX: nxt_st.repeaterBit = apbReq.pwdata[tenbase_t_pkg::REPEATER_BIT];
        tenbase_t_pkg::LOOPBACK_MASK_IDX: begin
          nxt_st.fdCrsTx = apbReq.pwdata[tenbase_t_pkg::FD_CRS_TX_BIT];
          nxt_st.loopback = apbReq.pwdata[tenbase_t_pkg::LOOPBACK_BIT];
        end
        tenbase_t_pkg::TEN_CFG_IDX: begin
          nxt_st.lowSq = apbReq.pwdata[tenbase_t_pkg::LOW_SQUELCH_BIT];
          nxt_st.cableStp = apbReq.pwdata[tenbase_t_pkg::CABLE_TYPE_BIT];
        end
        tenbase_t_pkg::TEN_CTRL_IDX: begin
          nxt_st.hbEn = apbReq.pwdata[tenbase_t_pkg::HEARTBEAT_BIT];
          nxt_st.linkIntEn = apbReq.pwdata[tenbase_t_pkg::LINK_INT_BIT];
        end
        default: ;
      endcase
    end

    // Read data is captured in the setup phase so it is stable in access
    if (apbReq.psel && !apbReq.penable) begin
      nxt_st.prdata = 32'h00000000;
      nxt_st.pslverr = 1'b0;
      case (idx)
        tenbase_t_pkg::PCS_CFG_IDX: nxt_st.prdata[tenbase_t_pkg::REPEATER_BIT] = st_ff.repeaterBit;
        tenbase_t_pkg::LOOPBACK_MASK_IDX: begin
          nxt_st.prdata[tenbase_t_pkg::FD_CRS_TX_BIT] = st_ff.fdCrsTx;
          nxt_st.prdata[tenbase_t_pkg::LOOPBACK_BIT] = st_ff.loopback;
        end
        tenbase_t_pkg::TEN_CFG_IDX: begin
          nxt_st.prdata[tenbase_t_pkg::LOW_SQUELCH_BIT] = st_ff.lowSq;
          nxt_st.prdata[tenbase_t_pkg::CABLE_TYPE_BIT] = st_ff.cableStp;
        end
        tenbase_t_pkg::TEN_CTRL_IDX: begin
          nxt_st.prdata[tenbase_t_pkg::HEARTBEAT_BIT] = st_ff.hbEn;
          nxt_st.prdata[tenbase_t_pkg::LINK_INT_BIT] = st_ff.linkIntEn;
        end
        tenbase_t_pkg::TEN_STAT_IDX: nxt_st.prdata[5:0] = {st_ff.crs, st_ff.col,
          rxActive, (st_ff.jab == tenbase_t_pkg::JAB_LOCK), st_ff.polBad, st_ff.linkGood};
        default: nxt_st.pslverr = 1'b1;
      endcase
    end

    // Smart squelch: three-crossing start qualification and idle end of packet
    nxt_st.sqCnt = (st_ff.sqCnt == 8'hff) ? st_ff.sqCnt : st_ff.sqCnt + 8'h01;
    case (st_ff.sq)
      tenbase_t_pkg::SQ_IDLE: begin
        nxt_st.sqCnt = 8'h00;
        if ((rxPosCross || rxNegCross) && linkOk && !st_ff.loopback) begin
          nxt_st.sq = tenbase_t_pkg::SQ_FIRST;
          nxt_st.sqFirstPos = rxPosCross;
        end
      end
      tenbase_t_pkg::SQ_FIRST: begin
        if (st_ff.sqCnt >= 8'(tenbase_t_pkg::SQ_WINDOW_CYC)) begin
          nxt_st.sq = tenbase_t_pkg::SQ_IDLE;
        end else if (st_ff.sqFirstPos ? rxNegCross : rxPosCross) begin
          nxt_st.sq = tenbase_t_pkg::SQ_SECOND;
          nxt_st.sqCnt = 8'h00;
        end
      end
      tenbase_t_pkg::SQ_SECOND: begin
        if (st_ff.sqCnt >= 8'(tenbase_t_pkg::SQ_WINDOW_CYC)) begin
          nxt_st.sq = tenbase_t_pkg::SQ_IDLE;
        end else if (st_ff.sqFirstPos ? rxPosCross : rxNegCross) begin
          nxt_st.sq = tenbase_t_pkg::SQ_VALID;
          nxt_st.sqCnt = 8'h00;
        end
      end
      tenbase_t_pkg::SQ_VALID: begin
        if (rxPosCross || rxNegCross) begin
          nxt_st.sqCnt = 8'h00;
        end else if (st_ff.sqCnt >= 8'(tenbase_t_pkg::SQ_IDLE_CYC)) begin
          nxt_st.sq = tenbase_t_pkg::SQ_IDLE;
        end
      end
      default: nxt_st.sq = tenbase_t_pkg::SQ_IDLE;
    endcase
    if (!linkOk || st_ff.loopback) begin
      nxt_st.sq = tenbase_t_pkg::SQ_IDLE;
    end

    // Collision filtered for seven bit times, held while it lasts
    if (collision) begin
      if (st_ff.colCnt >= 8'(tenbase_t_pkg::COL_CYC - 1)) begin
        nxt_st.colRep = 1'b1;
      end else begin
        nxt_st.colCnt = st_ff.colCnt + 8'h01;
      end
    end else begin
      nxt_st.colCnt = 8'h00;
      nxt_st.colRep = 1'b0;
    end

    // Heartbeat: delay after end of transmit, then a fixed pulse
    nxt_st.txEnPrev = txEn;
    if (st_ff.txEnPrev && !txEn && st_ff.hbEn && !fullDuplex && (st_ff.jab == tenbase_t_pkg::JAB_OK)) begin
      nxt_st.sqeArm = 1'b1;
      nxt_st.sqeOn = 1'b0;
      nxt_st.sqeCnt = 9'h000;
    end else if (st_ff.sqeArm) begin
      nxt_st.sqeCnt = st_ff.sqeCnt + 9'h001;
      if (st_ff.sqeCnt == 9'(tenbase_t_pkg::SQE_DELAY_CYC - 1)) begin
        nxt_st.sqeArm = 1'b0;
        nxt_st.sqeOn = 1'b1;
        nxt_st.sqeCnt = 9'h000;
      end
    end else if (st_ff.sqeOn) begin
      nxt_st.sqeCnt = st_ff.sqeCnt + 9'h001;
      if (st_ff.sqeCnt == 9'(tenbase_t_pkg::SQE_WIDTH_CYC - 1)) begin
        nxt_st.sqeOn = 1'b0;
      end
    end
    nxt_st.col = (collision && nxt_st.colRep) || nxt_st.sqeOn;

    // Carrier sense by duplex and repeater mode
    if (repeater) begin
      nxt_st.crs = rxActive;
    end else if (fullDuplex) begin
      nxt_st.crs = st_ff.fdCrsTx ? txEn : rxActive;
    end else begin
      nxt_st.crs = txEn || rxActive;
    end

    // Link pulse generator runs whenever no transmit data is present
    if (txEn) begin
      nxt_st.nlpCnt = 28'h0000000;
      nxt_st.nlpOn = 1'b0;
    end else if (st_ff.nlpOn) begin
      nxt_st.nlpW = st_ff.nlpW + 5'h01;
      if (st_ff.nlpW == 5'(tenbase_t_pkg::NLP_WIDTH_CYC - 1)) begin
        nxt_st.nlpOn = 1'b0;
      end
    end else if (st_ff.nlpCnt >= 28'(NLP_PERIOD - 1)) begin
      nxt_st.nlpCnt = 28'h0000000;
      nxt_st.nlpOn = 1'b1;
      nxt_st.nlpW = 5'h00;
    end else begin
      nxt_st.nlpCnt = bump(st_ff.nlpCnt);
    end

    // Link integrity: link pulses of either polarity or packets restart the loss timer
    if (linkPulseGood || linkPulseInverted || rxActive) begin
      nxt_st.linkGood = 1'b1;
      nxt_st.linkCnt = 28'h0000000;
    end else if (st_ff.linkCnt >= 28'(LINK_LOSS - 1)) begin
      nxt_st.linkGood = 1'b0;
    end else begin
      nxt_st.linkCnt = bump(st_ff.linkCnt);
    end

    // Jabber and unjab timing on the internal transmit enable
    case (st_ff.jab)
      tenbase_t_pkg::JAB_OK: begin
        nxt_st.jabCnt = txEn ? bump(st_ff.jabCnt) : 28'h0000000;
        if (txEn && st_ff.jabCnt >= 28'(JAB_LIMIT - 1)) begin
          nxt_st.jab = tenbase_t_pkg::JAB_LOCK;
          nxt_st.jabCnt = 28'h0000000;
        end
      end
      tenbase_t_pkg::JAB_LOCK: begin
        nxt_st.jabCnt = txEn ? 28'h0000000 : bump(st_ff.jabCnt);
        if (!txEn && st_ff.jabCnt >= 28'(UNJAB_LIMIT - 1)) begin
          nxt_st.jab = tenbase_t_pkg::JAB_OK;
          nxt_st.jabCnt = 28'h0000000;
        end
      end
      default: nxt_st.jab = tenbase_t_pkg::JAB_OK;
    endcase

    // Polarity detection counts consecutive inverted events and latches
    if (linkPulseInverted) begin
      if (st_ff.polLinkCnt == 3'(tenbase_t_pkg::POL_LINK_COUNT - 1)) begin
        nxt_st.polBad = 1'b1;
      end else begin
        nxt_st.polLinkCnt = st_ff.polLinkCnt + 3'h1;
      end
    end else if (linkPulseGood) begin
      nxt_st.polLinkCnt = 3'h0;
    end
    if (eopInverted) begin
      if (st_ff.polEopCnt == 2'(tenbase_t_pkg::POL_EOP_COUNT - 1)) begin
        nxt_st.polBad = 1'b1;
      end else begin
        nxt_st.polEopCnt = st_ff.polEopCnt + 2'h1;
      end
    end else if (eopGood) begin
      nxt_st.polEopCnt = 2'h0;
    end

    // Receive data path: loopback or polarity-corrected line data
    nxt_st.rxOut = st_ff.loopback ? txData : (rxDataIn ^ st_ff.polBad);

    // Transmit pair select; loopback and 100 Mb/s float both pairs
    nxt_st.utpOut = txActive ? txData : st_ff.nlpOn;
    nxt_st.stpOut = nxt_st.utpOut;
    nxt_st.utpOe = !speed100 && !st_ff.loopback && !st_ff.cableStp;
    nxt_st.stpOe = !speed100 && !st_ff.loopback && st_ff.cableStp;

    // Active-low status outputs
    nxt_st.leds.txN = !txActive;
    nxt_st.leds.rxN = !rxActive;
    nxt_st.leds.linkN = !(speed100 ? link100Good : (!st_ff.linkIntEn || st_ff.linkGood));
    nxt_st.leds.polarityN = !st_ff.polBad;
    nxt_st.leds.colN = !st_ff.col;
  end

  // State register; clock enable freezes everything except synchronous reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.sq <= tenbase_t_pkg::SQ_IDLE;
      st_ff.jab <= tenbase_t_pkg::JAB_OK;
      st_ff.hbEn <= tenbase_t_pkg::HEARTBEAT_RST;
      st_ff.linkIntEn <= tenbase_t_pkg::LINK_INT_RST;
      st_ff.leds <= '1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign apbRsp.prdata = st_ff.prdata;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && st_ff.pslverr;
  assign lowSquelchSelect = st_ff.lowSq;
  assign reducedThreshold = (st_ff.sq == tenbase_t_pkg::SQ_VALID);
  assign col = st_ff.col;
  assign crs = st_ff.crs;
  assign rxDataOut = st_ff.rxOut;
  assign polarityCorrect = st_ff.polBad;
  assign unshieldedTxOut = st_ff.utpOut;
  assign unshieldedTxOe = st_ff.utpOe;
  assign shieldedTxOut = st_ff.stpOut;
  assign shieldedTxOe = st_ff.stpOe;
  assign leds = st_ff.leds;

endmodule : tenbase_t_transceiver_control

`default_nettype wire

//--- tb/line_partner.sv
// Far-side model: squelch crossings during a burst, and normal link pulses.
// Assumes one clock; crossings arrive as one-cycle pulses, like the detector's.
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input wire logic clk,
  input wire logic burst,
  input wire logic slow,
  input wire logic linkOn,
  input wire logic linkInv,
  output logic rxPosCross,
  output logic rxNegCross,
  output logic linkPulseGood,
  output logic linkPulseInverted
);
  int tick = 0;
  int lp = 0;
  logic phase = 1'b0;
  initial {rxPosCross, rxNegCross, linkPulseGood, linkPulseInverted} = 4'h0;
  // Alternating crossings every 4 cycles, or every 41 when slow
  always @(posedge clk) begin
    rxPosCross <= 1'b0;
    rxNegCross <= 1'b0;
    tick <= burst ? tick + 1 : 0;
    if (!burst) phase <= 1'b0;
    else if (tick >= (slow ? 40 : 3)) begin
      tick <= 0;
      phase <= !phase;
      rxPosCross <= !phase;
      rxNegCross <= phase;
    end
  end
  // One link pulse every 250 cycles while enabled
  always @(posedge clk) begin
    lp <= (lp == 249) ? 0 : lp + 1;
    linkPulseGood <= linkOn && !linkInv && lp == 249;
    linkPulseInverted <= linkOn && linkInv && lp == 249;
  end
endmodule : line_partner
`default_nettype wire

//--- tb/tenbase_t_transceiver_control_sva.sv
// Checker for the transceiver control block, bound to its top ports.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tenbase_t_transceiver_control_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic fullDuplex,
  input wire logic repeaterStrap,
  input wire logic speed100,
  input wire logic txEn,
  input wire logic rxPosCross,
  input wire logic rxNegCross,
  input wire logic reducedThreshold,
  input wire logic col,
  input wire logic crs,
  input wire logic polarityCorrect,
  input wire logic unshieldedTxOe,
  input wire logic shieldedTxOe,
  input wire tenbase_t_pkg::led_t leds
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [5:0] idleCnt;
  logic [8:0] txCnt;
  // Cycles since the last crossing and of continuous transmit, saturating
  always_ff @(posedge clk) begin
    if (srst || rxPosCross || rxNegCross) idleCnt <= '0;
    else if (idleCnt != 6'h28) idleCnt <= idleCnt + 6'h01;
    if (srst || !txEn) txCnt <= '0;
    else if (txCnt != 9'h12c) txCnt <= txCnt + 9'h001;
  end
  a_fd_no_col: assert property (fullDuplex && $past(fullDuplex) |-> !col)
    else $error("collision in full duplex");
  a_eop_idle: assert property (idleCnt == 6'h22 |-> !reducedThreshold)
    else $error("valid data outlived quiet line");
  a_valid_crs: assert property ($rose(reducedThreshold) && !fullDuplex |=> crs)
    else $error("no carrier after qualified data");
  a_rep_crs: assert property (repeaterStrap && $past(repeaterStrap) && !reducedThreshold
    && !$past(reducedThreshold) |-> !crs)
    else $error("repeater carrier without receive");
  a_col_end: assert property ($fell(txEn) && !fullDuplex |-> ##2 !col)
    else $error("collision held after it ended");
  a_col_filter: assert property ($rose(col) && txEn |-> txCnt >= 9'h08c)
    else $error("collision reported too early");
  a_pair_one: assert property (!(unshieldedTxOe && shieldedTxOe))
    else $error("both pairs driven");
  a_pair_fast: assert property (speed100 && $past(speed100) |-> !unshieldedTxOe && !shieldedTxOe)
    else $error("pair driven at 100M");
  a_pol_hold: assert property (polarityCorrect |=> polarityCorrect)
    else $error("polarity latch cleared");
  a_pol_led: assert property (polarityCorrect && $past(polarityCorrect) |-> !leds.polarityN)
    else $error("polarity indicator off");
  c_col: cover property ($rose(col));
  c_valid: cover property ($rose(reducedThreshold));
  c_pol: cover property ($rose(polarityCorrect));
endmodule : tenbase_t_transceiver_control_sva
bind tenbase_t_transceiver_control tenbase_t_transceiver_control_sva chkInst (.clk, .srst, .fullDuplex,
  .repeaterStrap, .speed100, .txEn, .rxPosCross, .rxNegCross, .reducedThreshold, .col, .crs,
  .polarityCorrect, .unshieldedTxOe, .shieldedTxOe, .leds);
`default_nettype wire

//--- tb/tb_tenbase_t_transceiver_control.sv
// Testbench: APB register access plus line-side scenarios, half then full duplex.
// Assumes the package, design, partner model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_tenbase_t_transceiver_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fullDuplex = 1'b0;
  logic repeaterStrap = 1'b0;
  logic speed100 = 1'b0;
  logic txEn = 1'b0;
  logic txData = 1'b0;
  logic burst = 1'b0;
  logic slow = 1'b0;
  logic linkOn = 1'b1;
  logic linkInv = 1'b0;
  logic ce = 1'b1;
  logic link100Good = 1'b0, rxDataIn = 1'b0, eopGood = 1'b0, eopInverted = 1'b0;
  logic unshieldedTxOut;
  logic rxPosCross, rxNegCross, linkPulseGood, linkPulseInverted;
  logic col, crs, reducedThreshold, lowSquelchSelect, rxDataOut, polarityCorrect, unshieldedTxOe, shieldedTxOe;
  tenbase_t_pkg::apb_req_t apbReq = '0;
  tenbase_t_pkg::apb_rsp_t apbRsp;
  tenbase_t_pkg::led_t leds;
  logic [31:0] rd;
  logic err;
  int errCount = 0;
  int checkCount = 0;
  always #2.5 clk = ~clk;
  line_partner partner (.clk, .burst, .slow, .linkOn, .linkInv, .rxPosCross, .rxNegCross,
    .linkPulseGood, .linkPulseInverted);
  tenbase_t_transceiver_control #(.NLP_PERIOD(200), .JAB_LIMIT(300), .UNJAB_LIMIT(400), .LINK_LOSS(1000)) DUT (
    .clk, .srst, .ce, .apbReq, .apbRsp, .fullDuplex, .repeaterStrap, .speed100, .link100Good,
    .txEn, .txData, .rxDataIn, .rxPosCross, .rxNegCross, .linkPulseGood, .linkPulseInverted,
    .eopGood, .eopInverted, .lowSquelchSelect, .reducedThreshold, .col, .crs, .rxDataOut,
    .polarityCorrect, .unshieldedTxOut, .unshieldedTxOe, .shieldedTxOut(), .shieldedTxOe, .leds);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  // One APB transfer: setup cycle, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb
  task automatic wrap_up();
    if (errCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // Watchdog against a hang
  initial begin
    wait_n(20000);
    errCount++;
    wrap_up();
  end
  // Main sequence
  initial begin
    wait_n(8);
    srst <= 1'b0;
    wait_n(300);
    apb(1'b0, 8'h80, '0);
    chk("ctrl", rd, 32'h3);
    apb(1'b0, 8'h04, '0);
    chk("bad err", 32'(err), 32'h1);
    chk("bad data", rd, 32'h0);
    apb(1'b1, 8'h70, 32'hc);
    apb(1'b0, 8'h70, '0);
    chk("cfg", rd, 32'hc);
    wait_n(2);
    chk("lss", 32'(lowSquelchSelect), 32'h1);
    chk("oe", 32'({unshieldedTxOe, shieldedTxOe}), 32'h1);
    apb(1'b1, 8'h70, '0);
    // Slow crossings are rejected, quick ones qualify
    slow <= 1'b1;
    burst <= 1'b1;
    wait_n(200);
    chk("slow", 32'(reducedThreshold), 32'h0);
    burst <= 1'b0;
    slow <= 1'b0;
    wait_n(50);
    burst <= 1'b1;
    wait_n(20);
    chk("valid", 32'(reducedThreshold), 32'h1);
    chk("crs rx", 32'(crs), 32'h1);
    // Collision filter, end of collision, then heartbeat
    txEn <= 1'b1;
    wait_n(100);
    chk("col early", 32'(col), 32'h0);
    wait_n(70);
    chk("col", 32'(col), 32'h1);
    chk("leds", 32'(leds), 32'h2);
    txEn <= 1'b0;
    burst <= 1'b0;
    wait_n(3);
    chk("col end", 32'(col), 32'h0);
    wait_n(297);
    chk("sqe on", 32'(col), 32'h1);
    chk("crs idle", 32'(crs), 32'h0);
    wait_n(200);
    chk("sqe off", 32'(col), 32'h0);
    // One link pulse of 20 cycles on the idle pair
    @(posedge clk iff !unshieldedTxOut);
    @(posedge clk iff unshieldedTxOut);
    wait_n(19);
    chk("nlp on", 32'(unshieldedTxOut), 32'h1);
    wait_n(1);
    chk("nlp off", 32'(unshieldedTxOut), 32'h0);
    // Transmit alone, repeater strap, then jabber and unjab
    txEn <= 1'b1;
    wait_n(5);
    chk("crs tx", 32'(crs), 32'h1);
    repeaterStrap <= 1'b1;
    wait_n(5);
    chk("crs rep", 32'(crs), 32'h0);
    repeaterStrap <= 1'b0;
    wait_n(320);
    apb(1'b0, 8'h84, '0);
    chk("jab", 32'(rd[2]), 32'h1);
    txEn <= 1'b0;
    wait_n(300);
    apb(1'b0, 8'h84, '0);
    chk("jab hold", 32'(rd[2]), 32'h1);
    wait_n(150);
    apb(1'b0, 8'h84, '0);
    chk("unjab", 32'(rd[2]), 32'h0);
    speed100 <= 1'b1;
    wait_n(3);
    chk("oe fast", 32'({unshieldedTxOe, shieldedTxOe}), 32'h0);
    chk("link fast", 32'(leds.linkN), 32'h1);
    speed100 <= 1'b0;
    // Internal loopback
    apb(1'b1, 8'h60, 32'h800);
    txData <= 1'b1;
    txEn <= 1'b1;
    wait_n(3);
    chk("lb one", 32'(rxDataOut), 32'h1);
    chk("lb oe", 32'(unshieldedTxOe), 32'h0);
    txData <= 1'b0;
    wait_n(3);
    chk("lb zero", 32'(rxDataOut), 32'h0);
    txEn <= 1'b0;
    // Three inverted packet ends latch bad polarity
    repeat (3) begin
      eopInverted <= 1'b1;
      wait_n(1);
      eopInverted <= 1'b0;
      wait_n(1);
    end
    wait_n(2);
    chk("pol eop", 32'(polarityCorrect), 32'h1);
    // Full duplex run
    srst <= 1'b1;
    fullDuplex <= 1'b1;
    wait_n(8);
    srst <= 1'b0;
    wait_n(300);
    burst <= 1'b1;
    txEn <= 1'b1;
    wait_n(200);
    chk("fd col", 32'(col), 32'h0);
    chk("fd crs rx", 32'(crs), 32'h1);
    burst <= 1'b0;
    wait_n(40);
    chk("fd crs", 32'(crs), 32'h0);
    apb(1'b1, 8'h60, 32'h40);
    wait_n(3);
    chk("fd crs tx", 32'(crs), 32'h1);
    txEn <= 1'b0;
    // Link loss, integrity off, then inverted link pulses
    linkOn <= 1'b0;
    wait_n(1200);
    chk("link lost", 32'(leds.linkN), 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    wait_n(3);
    chk("link on", 32'(leds.linkN), 32'h0);
    linkInv <= 1'b1;
    linkOn <= 1'b1;
    repeat (6) @(posedge clk iff linkPulseInverted);
    wait_n(3);
    chk("pol six", 32'(polarityCorrect), 32'h0);
    @(posedge clk iff linkPulseInverted);
    wait_n(3);
    chk("pol", 32'(polarityCorrect), 32'h1);
    chk("pol fix", 32'(rxDataOut), 32'h1);
    chk("pol led", 32'(leds.polarityN), 32'h0);
    // Clock enable low freezes carrier sense
    ce <= 1'b0;
    txEn <= 1'b1;
    wait_n(3);
    chk("ce hold", 32'(crs), 32'h0);
    ce <= 1'b1;
    wait_n(3);
    chk("ce run", 32'(crs), 32'h1);
    wrap_up();
  end
endmodule : tb_tenbase_t_transceiver_control
`default_nettype wire
